// ### include/dij_pkg.sv
// Constants shared by the decrement, increment and jump execute block
package dij_pkg;
    // ==========================================================
    // Widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam int JADDR_W = 11;
    localparam int BUS_AW = 12;
    localparam int BUS_DW = 32;

    // ==========================================================
    // Opcode fields
    localparam int OP6_HI = 13;
    localparam int OP6_LO = 8;
    localparam logic [5:0] OP_DECREMENT_FILE_SKIP_ZERO = 6'h0b;
    localparam logic [5:0] OP_INCREMENT_FILE = 6'h0a;
    localparam int OP3_LO = 11;
    localparam logic [2:0] OP_ABSOLUTE_JUMP = 3'h5;
    localparam int DEST_BIT = 7;
    localparam int LATCH_PC_HI = 4;
    localparam int LATCH_PC_LO = 3;

    // ==========================================================
    // Register byte addresses
    localparam logic [11:0] ADR_CTRL = 12'h000;
    localparam logic [11:0] ADR_LATCH = 12'h004;
    localparam logic [11:0] ADR_WREG = 12'h008;
    localparam logic [11:0] ADR_STATUS = 12'h00c;
    localparam logic [11:0] ADR_PC = 12'h010;
    localparam logic [11:0] ADR_FILE_BASE = 12'h200;
    localparam int FILE_SEL_HI = 11;
    localparam int FILE_SEL_LO = 9;
    localparam logic [2:0] FILE_SEL = 3'h1;
    localparam int FILE_IDX_LO = 2;

    // ==========================================================
    // Field positions and reset values
    localparam int CTRL_RUN_BIT = 0;
    localparam int STATUS_ZERO_BIT = 0;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [13:0] INSTR_RST = 14'h0000;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] ZERO = 8'h00;
endpackage : dij_pkg

// ### include/dij_dec_if.sv
// Decoded instruction fields passed from the decoder to the core
`timescale 1ns/100ps
interface dij_dec_if;
    import dij_pkg::*;
    logic [INSTR_W-1:0] instr;
    logic is_dec;
    logic is_inc;
    logic is_jump;
    logic dest;
    logic [FADDR_W-1:0] faddr;
    logic [JADDR_W-1:0] jaddr;
    modport dec (input instr, output is_dec, is_inc, is_jump, dest, faddr, jaddr);
    modport core (output instr, input is_dec, is_inc, is_jump, dest, faddr, jaddr);
endinterface : dij_dec_if

// ### rtl/dij_decoder.sv
// Opcode decoder for the three executed instructions
`timescale 1ns/100ps
module dij_decoder
    import dij_pkg::*;
(
    dij_dec_if.dec dbus // Instruction in, decoded fields out
);
    assign dbus.is_dec = (dbus.instr[OP6_HI:OP6_LO] == OP_DECREMENT_FILE_SKIP_ZERO);
    assign dbus.is_inc = (dbus.instr[OP6_HI:OP6_LO] == OP_INCREMENT_FILE);
    assign dbus.is_jump = (dbus.instr[OP6_HI:OP3_LO] == OP_ABSOLUTE_JUMP);
    assign dbus.dest = dbus.instr[DEST_BIT];
    assign dbus.faddr = dbus.instr[FADDR_W-1:0];
    assign dbus.jaddr = dbus.instr[JADDR_W-1:0];
endmodule : dij_decoder

// ### rtl/dij_core.sv
// Fetch and execute core with Avalon-MM register access
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps

// Behaviour
// - Decrement-and-skip reads the file register named by the low 7 bits, subtracts one, no flag moves.
// - For decrement-and-skip and increment, destination bit 0 writes W and 1 writes the file register.
// - A zero decrement result skips the next instruction, otherwise execution runs on in sequence.
// - A taken skip turns the prefetched word into a no-operation, costing one extra cycle.
// - Increment adds one to the file register in one cycle and sets zero only for a zero result.
// - The jump loads its 11-bit immediate into program counter bits 10 to 0.
// - The jump fills program counter bits 12 and 11 from latch-high bits 4 and 3.
// - The jump is always taken and leaves every status flag unchanged.
// - The jump takes two cycles because the prefetched word is flushed.
module dij_core
    import dij_pkg::*;
(
    input wire logic clock, // 25 MHz clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [BUS_AW-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [BUS_DW-1:0] avs_writedata, // Write data
    output logic [BUS_DW-1:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic [PC_W-1:0] prog_addr, // Fetch address
    input wire logic [INSTR_W-1:0] prog_data // Word at fetch address
);
    // ==========================================================
    // State
    logic run_r;
    logic [DATA_W-1:0] latch_r;
    logic [DATA_W-1:0] w_r;
    logic zero_r;
    logic [PC_W-1:0] pc_r;
    logic [INSTR_W-1:0] ir_r;
    logic ir_valid_r;
    logic rd_done_r;
    logic [DATA_W-1:0] file_mem [0:(1<<FADDR_W)-1];

    dij_dec_if dbus ();
    dij_decoder u_dec (
        .dbus(dbus.dec)
    );
    assign dbus.instr = ir_r;

    // ==========================================================
    // Execute
    logic exec;
    logic [DATA_W-1:0] f_val;
    logic [DATA_W-1:0] dec_res;
    logic [DATA_W-1:0] inc_res;
    logic [DATA_W-1:0] result;
    logic core_w_we;
    logic core_f_we;
    logic core_z_we;
    logic skip;
    logic exec_jump;
    logic [PC_W-1:0] jump_target;

    assign exec = run_r & ir_valid_r;
    assign f_val = file_mem[dbus.faddr];
    assign dec_res = f_val - ONE;
    assign inc_res = f_val + ONE;
    assign result = dbus.is_dec ? dec_res : inc_res;
    assign core_w_we = exec & (dbus.is_dec | dbus.is_inc) & ~dbus.dest;
    assign core_f_we = exec & (dbus.is_dec | dbus.is_inc) & dbus.dest;
    assign core_z_we = exec & dbus.is_inc;
    assign skip = exec & dbus.is_dec & (dec_res == ZERO);
    assign exec_jump = exec & dbus.is_jump;
    assign jump_target = {latch_r[LATCH_PC_HI:LATCH_PC_LO], dbus.jaddr};

    // ==========================================================
    // Bus decode
    logic sel_ctrl;
    logic sel_latch;
    logic sel_w;
    logic sel_st;
    logic sel_pc;
    logic sel_file;
    logic wr_conflict;
    logic sw_wr_ok;
    logic sw_st_we;
    logic sw_pc_we;
    logic [FADDR_W-1:0] sw_idx;

    assign sel_ctrl = (avs_address == ADR_CTRL);
    assign sel_latch = (avs_address == ADR_LATCH);
    assign sel_w = (avs_address == ADR_WREG);
    assign sel_st = (avs_address == ADR_STATUS);
    assign sel_pc = (avs_address == ADR_PC);
    assign sel_file = (avs_address[FILE_SEL_HI:FILE_SEL_LO] == FILE_SEL)
        & (avs_address[1:0] == 2'h0);
    assign sw_idx = avs_address[FILE_IDX_LO+FADDR_W-1:FILE_IDX_LO];
    // Software write waits while the core updates the same target
    assign wr_conflict = avs_write & ((sel_w & core_w_we) | (sel_file & core_f_we)
        | (sel_st & core_z_we) | (sel_pc & run_r));
    assign sw_wr_ok = avs_write & ~wr_conflict;
    assign sw_st_we = sw_wr_ok & sel_st;
    assign sw_pc_we = sw_wr_ok & sel_pc;
    assign avs_waitrequest = (avs_read & ~rd_done_r) | wr_conflict;
    assign prog_addr = pc_r;

    // ==========================================================
    // Control registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            run_r <= 1'b0;
            latch_r <= LATCH_RST;
        end
        else
        begin
            if (sw_wr_ok & sel_ctrl)
                run_r <= avs_writedata[CTRL_RUN_BIT];
            if (sw_wr_ok & sel_latch)
                latch_r <= avs_writedata[DATA_W-1:0];
        end
    end

    // Working accumulator
    always_ff @(posedge clock)
    begin
        if (rst)
            w_r <= WREG_RST;
        else if (core_w_we)
            w_r <= result;
        else if (sw_wr_ok & sel_w)
            w_r <= avs_writedata[DATA_W-1:0];
    end

    // Zero flag
    always_ff @(posedge clock)
    begin
        if (rst)
            zero_r <= 1'b0;
        else if (core_z_we)
            zero_r <= (inc_res == ZERO);
        else if (sw_st_we)
            zero_r <= avs_writedata[STATUS_ZERO_BIT];
    end

    // File registers
    always_ff @(posedge clock)
    begin
        if (core_f_we)
            file_mem[dbus.faddr] <= result;
        else if (sw_wr_ok & sel_file)
            file_mem[sw_idx] <= avs_writedata[DATA_W-1:0];
    end

    // Program counter
    always_ff @(posedge clock)
    begin
        if (rst)
            pc_r <= PC_RST;
        else if (sw_pc_we)
            pc_r <= avs_writedata[PC_W-1:0];
        else if (run_r)
        begin
            if (exec_jump)
                pc_r <= jump_target;
            else
                pc_r <= pc_r + 13'h0001;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ir_r <= INSTR_RST;
            ir_valid_r <= 1'b0;
        end
        else if (sw_pc_we)
            ir_valid_r <= 1'b0;
        else if (run_r)
        begin
            ir_r <= prog_data;
            ir_valid_r <= ~(exec_jump | skip);
        end
    end

    // Read path, one wait state
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rd_done_r <= 1'b0;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            rd_done_r <= avs_read & ~rd_done_r;
            if (avs_read & ~rd_done_r)
            begin
                avs_readdata <= 32'h00000000;
                if (sel_ctrl)
                    avs_readdata[CTRL_RUN_BIT] <= run_r;
                else if (sel_latch)
                    avs_readdata[DATA_W-1:0] <= latch_r;
                else if (sel_w)
                    avs_readdata[DATA_W-1:0] <= w_r;
                else if (sel_st)
                    avs_readdata[STATUS_ZERO_BIT] <= zero_r;
                else if (sel_pc)
                    avs_readdata[PC_W-1:0] <= pc_r;
                else if (sel_file)
                    avs_readdata[DATA_W-1:0] <= file_mem[sw_idx];
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_dec_exec;
        exec && dbus.is_dec;
    endsequence
    sequence s_jmp_exec;
        exec && dbus.is_jump;
    endsequence

    property p_dec_w;
        s_dec_exec ##0 !dbus.dest |=> w_r == $past(dec_res);
    endproperty
    a_dec_w: assert property (p_dec_w) else $error("decrement result not in W");

    property p_dec_file;
        s_dec_exec ##0 dbus.dest |=> file_mem[$past(dbus.faddr)] == $past(dec_res);
    endproperty
    a_dec_file: assert property (p_dec_file) else $error("decrement not written back");

    property p_dec_flag;
        s_dec_exec ##0 !sw_st_we |=> $stable(zero_r);
    endproperty
    a_dec_flag: assert property (p_dec_flag) else $error("decrement changed zero flag");

    property p_skip;
        s_dec_exec ##0 dec_res == ZERO |=> !ir_valid_r ##0 !exec;
    endproperty
    a_skip: assert property (p_skip) else $error("zero result did not skip");

    property p_no_skip;
        s_dec_exec ##0 dec_res != ZERO ##0 !sw_pc_we |=> ir_valid_r;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("nonzero result skipped");

    property p_inc_zero;
        exec && dbus.is_inc |=> zero_r == ($past(inc_res) == ZERO);
    endproperty
    a_inc_zero: assert property (p_inc_zero) else $error("zero flag wrong after increment");

    property p_jump_pc;
        s_jmp_exec ##0 !sw_pc_we |=> pc_r[JADDR_W-1:0] == $past(dbus.jaddr)
            && pc_r[PC_W-1:JADDR_W] == $past(latch_r[LATCH_PC_HI:LATCH_PC_LO]);
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

    property p_jump_flag;
        s_jmp_exec ##0 !sw_st_we |=> $stable(zero_r);
    endproperty
    a_jump_flag: assert property (p_jump_flag) else $error("jump changed zero flag");

    property p_jump_flush;
        s_jmp_exec |=> !exec ##1 (exec || !run_r || !ir_valid_r);
    endproperty
    a_jump_flush: assert property (p_jump_flush) else $error("jump did not flush");

    property p_fetch;
        run_r && !sw_pc_we |=> ir_r == $past(prog_data);
    endproperty
    a_fetch: assert property (p_fetch) else $error("prefetch word lost");
endmodule : dij_core

// ### dv/tb.sv
// Self-checking testbench for the decrement, increment and jump execute core
`timescale 1ns/100ps
module tb
    import dij_pkg::*;
;
    logic clock;
    logic rst;
    logic [BUS_AW-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [BUS_DW-1:0] avs_writedata;
    logic [BUS_DW-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [PC_W-1:0] prog_addr;
    logic [INSTR_W-1:0] prog_data;
    logic [INSTR_W-1:0] prog_mem [0:8191];
    logic [31:0] rd;
    int failures;
    int tests_run;

    assign prog_data = prog_mem[prog_addr];

    dij_core u_dut
    (
        .clock(clock),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .prog_addr(prog_addr),
        .prog_data(prog_data)
    );

    // ==========================================================
    // Helpers
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 200);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 200)
        begin
            failures++;
            $display("unexpected at %0t: bus stalled", $time);
        end
    endtask : bus

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    function automatic logic [11:0] fa(input logic [6:0] i);
        return ADR_FILE_BASE + {3'h0, i, 2'h0};
    endfunction : fa

    function automatic logic [13:0] fop(input logic [5:0] op, input logic d,
                                        input logic [6:0] f);
        return {op, d, f};
    endfunction : fop

    function automatic logic [13:0] jop(input logic [10:0] k);
        return {OP_ABSOLUTE_JUMP, k};
    endfunction : jop

    task automatic run(input int n);
        bus(1'b1, ADR_CTRL, 32'h1);
        repeat (n) @(posedge clock);
        bus(1'b1, ADR_CTRL, 32'h0);
    endtask : run

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_chk(ADR_CTRL, 32'h0);
        rd_chk(ADR_LATCH, 32'h0);
        rd_chk(ADR_WREG, 32'h0);
        rd_chk(ADR_STATUS, 32'h0);
        rd_chk(ADR_PC, 32'h0);
        bus(1'b1, 12'h100, 32'hffffffff);
        rd_chk(12'h100, 32'h0);
        bus(1'b1, ADR_WREG, 32'hffffffff);
        rd_chk(ADR_WREG, 32'hff);
    endtask : t_regs

    // Wrap to zero, zero-result skip, and destination routing
    task automatic t_skip();
        bus(1'b1, fa(7'd3), 32'h05);
        bus(1'b1, fa(7'd4), 32'hff);
        bus(1'b1, fa(7'd5), 32'h01);
        bus(1'b1, fa(7'd6), 32'h20);
        bus(1'b1, ADR_STATUS, 32'h1);
        bus(1'b1, ADR_WREG, 32'h77);
        bus(1'b1, ADR_PC, 32'h0);
        prog_mem[0] = fop(OP_INCREMENT_FILE, 1'b1, 7'd4);
        prog_mem[1] = fop(OP_DECREMENT_FILE_SKIP_ZERO, 1'b0, 7'd5);
        prog_mem[2] = fop(OP_INCREMENT_FILE, 1'b1, 7'd6);
        prog_mem[3] = fop(OP_DECREMENT_FILE_SKIP_ZERO, 1'b1, 7'd3);
        prog_mem[4] = jop(11'h004);
        run(12);
        rd_chk(fa(7'd4), 32'h00);
        rd_chk(ADR_STATUS, 32'h1);
        rd_chk(fa(7'd3), 32'h04);
        rd_chk(ADR_WREG, 32'h00);
        rd_chk(fa(7'd5), 32'h01);
        rd_chk(fa(7'd6), 32'h20);
    endtask : t_skip

    // Increment to W clears zero; nonzero decrement does not skip
    task automatic t_noskip();
        bus(1'b1, fa(7'd7), 32'h03);
        bus(1'b1, fa(7'd8), 32'h40);
        bus(1'b1, ADR_PC, 32'h10);
        prog_mem[16] = fop(OP_INCREMENT_FILE, 1'b0, 7'd4);
        prog_mem[17] = fop(OP_DECREMENT_FILE_SKIP_ZERO, 1'b1, 7'd7);
        prog_mem[18] = fop(OP_INCREMENT_FILE, 1'b1, 7'd8);
        prog_mem[19] = jop(11'h013);
        run(12);
        rd_chk(ADR_WREG, 32'h01);
        rd_chk(fa(7'd4), 32'h00);
        rd_chk(ADR_STATUS, 32'h0);
        rd_chk(fa(7'd7), 32'h02);
        rd_chk(fa(7'd8), 32'h41);
    endtask : t_noskip

    // Jump target from immediate and latch bits, one flushed fetch
    task automatic t_jump();
        bus(1'b1, ADR_LATCH, 32'hef);
        bus(1'b1, fa(7'd9), 32'h30);
        bus(1'b1, ADR_STATUS, 32'h1);
        bus(1'b1, ADR_PC, 32'h20);
        prog_mem[32] = jop(11'h555);
        prog_mem[33] = fop(OP_INCREMENT_FILE, 1'b1, 7'd9);
        prog_mem[13'h0d55] = jop(11'h555);
        bus(1'b1, ADR_CTRL, 32'h1);
        for (int n = 0; n < 8 && prog_addr !== 13'h0021; n++)
            @(posedge clock);
        @(posedge clock);
        check(32'(prog_addr), 32'h0d55);
        repeat (4) @(posedge clock);
        bus(1'b1, ADR_CTRL, 32'h0);
        rd_chk(ADR_STATUS, 32'h1);
        rd_chk(fa(7'd9), 32'h30);
    endtask : t_jump

    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        failures = 0;
        tests_run = 0;
        rst = 1'b1;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        for (int i = 0; i < 8192; i++)
            prog_mem[i] = 14'h0000;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_skip();
        t_noskip();
        t_jump();
        end_of_test();
    end

    initial
    begin
        #(40 * 20000);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : tb
